// file: src/uart_pkg.sv
// Register map, field positions, resets and state codes of the serial transceiver.
// Assumes a 32-bit Avalon-MM slave with byte addresses; one register per word.
package uart_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [4:0] REG_MODE = 5'h00;
  localparam logic [4:0] REG_STA = 5'h04;
  localparam logic [4:0] REG_TXDATA = 5'h08;
  localparam logic [4:0] REG_RXDATA = 5'h0C;
  localparam logic [4:0] REG_BRG = 5'h10;
  localparam logic [4:0] REG_ISTS = 5'h14;
  localparam logic [4:0] REG_IMASK = 5'h18;
  // ==========================================
  // Mode register fields
  localparam int MODE_ON = 15;
  localparam int MODE_INFRARED_ENABLE_BIT = 12;
  localparam int MODE_PE_LO = 8;
  localparam int MODE_HIGH_SPEED_BAUD_SELECT = 3;
  localparam int MODE_PD_LO = 1;
  localparam int MODE_STSEL = 0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] BRG_RST = 16'h0000;
  // ==========================================
  // Status register fields
  localparam int STA_TXISEL_LO = 14;
  localparam int STA_BRK = 11;
  localparam int STA_TXEN = 10;
  localparam int STA_TXFULL = 9;
  localparam int STA_TRMT = 8;
  localparam int STA_RXISEL_LO = 6;
  localparam int STA_PARITY_ERROR_FLAG = 3;
  localparam int STA_FRAMING_ERROR_FLAG = 2;
  localparam int STA_OVERRUN_FLAG = 1;
  localparam int STA_RXAV = 0;
  // ==========================================
  // Interrupt status bits
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_ERR = 2;
  // ==========================================
  // Pin enable codes, parity codes, counts
  localparam logic [1:0] PE_NONE = 2'h0;
  localparam logic [1:0] PE_CTS_RTS = 2'h2;
  localparam logic [1:0] PE_BCLK = 2'h3;
  localparam logic [1:0] PD_EVEN = 2'h1;
  localparam logic [1:0] PD_ODD = 2'h2;
  localparam logic [1:0] PD_NINE = 2'h3;
  localparam logic [3:0] OS_LAST_STD = 4'hF;
  localparam logic [3:0] OS_LAST_HS = 4'h3;
  localparam logic [3:0] BRK_BITS = 4'hD;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [2:0] RX_WM_34 = 3'h3;
  // ==========================================
  // State codes
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_BRK = 3'b001, TX_START = 3'b010,
    TX_DATA = 3'b011, TX_PAR = 3'b100, TX_STOP = 3'b101
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR = 3'b011, RX_STOP = 3'b100
  } rx_state_t;
endpackage : uart_pkg

// file: src/uart_baud.sv
// Baud generator: oversample tick, bit tick, bit phase and oversample clock (16x baud, 4x in high speed).
// Assumes brg holds divisor minus one in mclk periods per oversample tick.
`timescale 1ns/1ps
module uart_baud
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic clr,
  input wire logic [15:0] brg,
  input wire logic high_speed_baud_select,
  // Ticks
  output logic os_tick,
  output logic bit_tick,
  output logic [3:0] phase,
  output logic clk16
);
  logic [15:0] cnt_q, cnt_d;
  logic [3:0] ph_q, ph_d;
  logic clk_q, clk_d;
  logic [3:0] last;

  // ==========================================
  // Counters
  always_comb
  begin
    last = high_speed_baud_select ? OS_LAST_HS : OS_LAST_STD;
    os_tick = en && (cnt_q == brg);
    bit_tick = os_tick && (ph_q == last);
    cnt_d = os_tick ? 16'h0000 : cnt_q + 16'h0001;
    ph_d = bit_tick ? 4'h0 : (os_tick ? ph_q + 4'h1 : ph_q);
    clk_d = cnt_q <= (brg >> 1);
    // Restart from a cleared state so shifting begins on a whole bit
    if (!en || clr)
    begin
      cnt_d = 16'h0000;
      ph_d = 4'h0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      ph_q <= 4'h0;
      clk_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      clk_q <= clk_d;
    end
  end

  assign phase = ph_q;
  assign clk16 = clk_q;
endmodule : uart_baud

// file: src/uart_rx.sv
// Character receiver: oversampled start detect, mid-bit sampling, checks.
// Assumes rxd is already decoded and synchronous to mclk; idle level is high.
`timescale 1ns/1ps
module uart_rx
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic os_tick,
  input wire logic high_speed_baud_select,
  input wire logic [1:0] pd,
  input wire logic rxd,
  // Character out
  output logic valid,
  output logic [8:0] data,
  output logic parity_error_flag,
  output logic framing_error_flag
);
  rx_state_t st_q, st_d;
  logic [3:0] os_q, os_d;
  logic [3:0] n_q, n_d;
  logic [8:0] sh_q, sh_d;
  logic pe_q, pe_d;
  logic [3:0] last;
  logic [3:0] nlast;
  logic samp;
  logic rxd_q;

  // ==========================================
  // Receive sequencer
  always_comb
  begin
    last = high_speed_baud_select ? OS_LAST_HS : OS_LAST_STD;
    nlast = (pd == PD_NINE) ? 4'h8 : 4'h7;
    st_d = st_q;
    os_d = os_tick ? os_q + 4'h1 : os_q;
    n_d = n_q;
    sh_d = sh_q;
    pe_d = pe_q;
    valid = 1'b0;
    // Start bit is checked at mid-bit, later bits a full bit apart
    samp = os_tick && (os_q == ((st_q == RX_START) ? (last >> 1) : last));
    case (st_q)
      RX_IDLE:
      begin
        os_d = 4'h0;
        // Falling edge only, so a low stop bit cannot restart a frame
        if (rxd_q && !rxd)
          st_d = RX_START;
      end
      RX_START:
        if (samp)
        begin
          st_d = rxd ? RX_IDLE : RX_DATA;
          os_d = 4'h0;
          n_d = 4'h0;
          sh_d = 9'h000;
        end
      RX_DATA:
        if (samp)
        begin
          os_d = 4'h0;
          sh_d = {rxd, sh_q[8:1]};
          n_d = n_q + 4'h1;
          if (n_q == nlast)
          begin
            if (pd == PD_NINE)
              st_d = RX_STOP;
            else
            begin
              sh_d = {1'b0, rxd, sh_q[8:2]};
              st_d = (pd == PD_EVEN || pd == PD_ODD) ? RX_PAR : RX_STOP;
            end
          end
        end
      RX_PAR:
        if (samp)
        begin
          os_d = 4'h0;
          pe_d = (^sh_q[7:0]) ^ rxd ^ (pd == PD_ODD);
          st_d = RX_STOP;
        end
      RX_STOP:
        if (samp)
        begin
          valid = 1'b1;
          st_d = RX_IDLE;
        end
      default:
        st_d = RX_IDLE;
    endcase
    if (st_q == RX_START && !samp)
      pe_d = 1'b0;
    if (!en)
      st_d = RX_IDLE;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= RX_IDLE;
      os_q <= 4'h0;
      n_q <= 4'h0;
      sh_q <= 9'h000;
      pe_q <= 1'b0;
      rxd_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      os_q <= os_d;
      n_q <= n_d;
      sh_q <= sh_d;
      pe_q <= pe_d;
      rxd_q <= rxd;
    end
  end

  assign data = sh_q;
  assign parity_error_flag = pe_q;
  assign framing_error_flag = !rxd;
endmodule : uart_rx

// file: src/uart_tx_rx_break_infrared.sv
// Serial transceiver with break/sync, flow-control pins and infrared coding.
// Assumes an Avalon-MM master on mclk; line pins synchronous to mclk.
//
// Notes on behaviour
// - Setting transmit enable raises the transmit interrupt two cycles later.
// - 8-bit writes enter the transmit FIFO; output starts next baud edge.
// - Enabling after a load starts shifting at once, baud clock restarted.
// - Transmit interrupt condition follows the transmit interrupt select field.
// - 9-bit mode accepts only full 16-bit writes of transmit data.
// - With break requested, the next written character only triggers a break.
// - After a finished break hardware clears break request, then sends sync.
// - Receive interrupt follows the receive interrupt select field.
// - Overrun flag stays set until software clears it.
// - Reading receive data pops the FIFO; error flags follow the new head.
// - Pin enable field selects use of clear-to-send and request-to-send.
// - Infrared modes work only with high-speed baud select cleared.
// - Pin enable 11 with module on drives the oversample clock out: 16x baud, 4x with high-speed baud select.
// - Infrared enable selects the built-in encoder and decoder on the pins.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module uart_tx_rx_break_infrared
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt
  output logic irq,
  // Line pins
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  input wire logic clear_to_send_pin_n,
  output logic request_to_send_pin_n
);
  import uart_pkg::*;

  // ==========================================
  // State
  logic [15:0] mode_q, mode_d, brg_q, brg_d;
  logic txen_q, txen_d, brk_q, brk_d, brk_tag_q, brk_tag_d, overrun_flag_q, overrun_flag_d;
  logic [1:0] txis_q, txis_d, rxis_q, rxis_d;
  logic [2:0] ists_q, ists_d, imask_q, imask_d;
  logic wait_q, wait_d, irq_q, irq_d, txd_q, txd_d, rts_q, rts_d;
  logic [31:0] rdata_q, rdata_d;
  logic txen_p_q, ev1_q, ev1_d, txc_q, txc_d, rxc_q, rxc_d;
  logic [9:0] txf_q [FIFO_DEPTH];
  logic [9:0] txf_d [FIFO_DEPTH];
  logic [10:0] rxf_q [FIFO_DEPTH];
  logic [10:0] rxf_d [FIFO_DEPTH];
  logic [2:0] tw_q, tw_d, tr_q, tr_d, rw_q, rw_d, rr_q, rr_d;
  tx_state_t ts_q, ts_d;
  logic [8:0] sh_q, sh_d;
  logic [3:0] bc_q, bc_d, irc_q, irc_d;
  logic par_q, par_d;

  // ==========================================
  // Combinational helpers
  logic on, nine, ir_act, acc, wr, rd, txen_rise, tx_empty, tx_full, rx_full;
  logic [2:0] rx_cnt, tx_cnt;
  logic [15:0] wm, sta;
  logic os_tick, bit_tick, clk16, line, cts_ok, rx_line, txc, rxc;
  logic [3:0] phase;
  logic [8:0] rx_data;
  logic rx_valid, rx_parity_error_flag, rx_framing_error_flag;
  logic [1:0] pd;

  assign on = mode_q[MODE_ON];
  assign pd = mode_q[MODE_PD_LO +: 2];
  assign nine = pd == PD_NINE;
  assign ir_act = on && mode_q[MODE_INFRARED_ENABLE_BIT] && !mode_q[MODE_HIGH_SPEED_BAUD_SELECT];
  assign acc = (read || write) && !wait_q;
  assign wr = acc && write;
  assign rd = acc && read;
  assign txen_rise = txen_q && !txen_p_q;
  assign tx_cnt = tw_q - tr_q;
  assign rx_cnt = rw_q - rr_q;
  assign tx_empty = tx_cnt == 3'h0;
  assign tx_full = tx_cnt == FIFO_DEPTH;
  assign rx_full = rx_cnt == FIFO_DEPTH;
  assign wm = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign cts_ok = (mode_q[MODE_PE_LO +: 2] != PE_CTS_RTS) || !clear_to_send_pin_n;
  assign rx_line = ir_act ? (irc_q == 4'h0) : serial_receive_pin;

  uart_baud u_baud (
    .mclk(mclk), .rst(rst), .en(on), .clr(txen_rise),
    .brg(brg_q), .high_speed_baud_select(mode_q[MODE_HIGH_SPEED_BAUD_SELECT]),
    .os_tick(os_tick), .bit_tick(bit_tick), .phase(phase), .clk16(clk16)
  );

  uart_rx u_rx (
    .mclk(mclk), .rst(rst), .en(on), .os_tick(os_tick),
    .high_speed_baud_select(mode_q[MODE_HIGH_SPEED_BAUD_SELECT]), .pd(pd), .rxd(rx_line),
    .valid(rx_valid), .data(rx_data), .parity_error_flag(rx_parity_error_flag), .framing_error_flag(rx_framing_error_flag)
  );

  // ==========================================
  // Registers, FIFOs and interrupts
  always_comb
  begin
    mode_d = mode_q;
    brg_d = brg_q;
    txen_d = txen_q;
    brk_d = brk_q;
    brk_tag_d = brk_tag_q && brk_q;
    txis_d = txis_q;
    rxis_d = rxis_q;
    overrun_flag_d = overrun_flag_q;
    ists_d = ists_q;
    imask_d = imask_q;
    txf_d = txf_q;
    rxf_d = rxf_q;
    tw_d = tw_q;
    rw_d = rw_q;
    rr_d = rr_q;
    wait_d = !((read || write) && wait_q);
    sta = 16'h0000;
    sta[STA_TXISEL_LO +: 2] = txis_q;
    sta[STA_BRK] = brk_q;
    sta[STA_TXEN] = txen_q;
    sta[STA_TXFULL] = tx_full;
    sta[STA_TRMT] = tx_empty && ts_q == TX_IDLE;
    sta[STA_RXISEL_LO +: 2] = rxis_q;
    sta[STA_PARITY_ERROR_FLAG] = rxf_q[rr_q[1:0]][10];
    sta[STA_FRAMING_ERROR_FLAG] = rxf_q[rr_q[1:0]][9];
    sta[STA_OVERRUN_FLAG] = overrun_flag_q;
    sta[STA_RXAV] = rx_cnt != 3'h0;
    rdata_d = rdata_q;
    // Writes leave read data alone; it stands until the next read
    if (read && wait_q)
    begin
      case (address)
        REG_MODE: rdata_d = {16'h0000, mode_q};
        REG_STA: rdata_d = {16'h0000, sta};
        REG_RXDATA: rdata_d = {23'h000000, rxf_q[rr_q[1:0]][8:0]};
        REG_BRG: rdata_d = {16'h0000, brg_q};
        REG_ISTS: rdata_d = {29'h00000000, ists_q};
        REG_IMASK: rdata_d = {29'h00000000, imask_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (wr)
    begin
      case (address)
        REG_MODE: mode_d = (writedata[15:0] & wm) | (mode_q & ~wm);
        REG_BRG: brg_d = (writedata[15:0] & wm) | (brg_q & ~wm);
        REG_IMASK: if (byteenable[0]) imask_d = writedata[2:0];
        REG_ISTS: if (byteenable[0]) ists_d = ists_q & ~writedata[2:0];
        REG_STA:
        begin
          if (byteenable[1])
          begin
            txis_d = writedata[STA_TXISEL_LO +: 2];
            brk_d = writedata[STA_BRK];
            txen_d = writedata[STA_TXEN];
          end
          if (byteenable[0])
          begin
            rxis_d = writedata[STA_RXISEL_LO +: 2];
            overrun_flag_d = overrun_flag_q && writedata[STA_OVERRUN_FLAG];
          end
        end
        REG_TXDATA:
          // Bytes alone are dropped in 9-bit mode; a split load would corrupt bit 8
          if ((nine ? byteenable[1:0] == 2'b11 : byteenable[0]) && !tx_full)
          begin
            txf_d[tw_q[1:0]] = {brk_q && !brk_tag_q, nine ? writedata[8] : 1'b0,
              writedata[7:0]};
            brk_tag_d = brk_q;
            tw_d = tw_q + 3'h1;
          end
        default: ;
      endcase
    end
    if (rd && address == REG_RXDATA && rx_cnt != 3'h0)
      rr_d = rr_q + 3'h1;
    if (rx_valid)
    begin
      if (rx_full)
        overrun_flag_d = 1'b1;
      else
      begin
        rxf_d[rw_q[1:0]] = {rx_parity_error_flag, rx_framing_error_flag, rx_data};
        rw_d = rw_q + 3'h1;
      end
    end
    if (ts_q == TX_BRK && bit_tick && bc_q == BRK_BITS)
      brk_d = 1'b0;
    case (txis_q)
      2'h1: txc = tx_empty && ts_q == TX_IDLE;
      2'h2: txc = tx_empty;
      default: txc = !tx_full;
    endcase
    case (rxis_q)
      2'h2: rxc = rx_cnt >= RX_WM_34;
      2'h3: rxc = rx_full;
      default: rxc = rx_cnt != 3'h0;
    endcase
    txc_d = txc && txen_q;
    rxc_d = rxc;
    ev1_d = txen_rise;
    // Set wins over a same-cycle write-one clear
    if (ev1_q || (txc_d && !txc_q))
      ists_d[IRQ_TX] = 1'b1;
    if (rxc && !rxc_q)
      ists_d[IRQ_RX] = 1'b1;
    if (rx_valid && (rx_full || rx_parity_error_flag || rx_framing_error_flag))
      ists_d[IRQ_ERR] = 1'b1;
    irq_d = |(ists_q & imask_q);
    if (ts_q == TX_IDLE && ts_d != TX_IDLE)
      tr_d = tr_q + 3'h1;
    else
      tr_d = tr_q;
  end

  // ==========================================
  // Transmitter
  always_comb
  begin
    ts_d = ts_q;
    sh_d = sh_q;
    bc_d = bc_q;
    par_d = par_q;
    line = 1'b1;
    case (ts_q)
      TX_IDLE:
        // Enable edge starts at once since the baud clock was just cleared
        if (on && txen_q && !tx_empty && cts_ok && (bit_tick || txen_rise))
        begin
          bc_d = 4'h0;
          sh_d = txf_q[tr_q[1:0]][8:0];
          par_d = (^txf_q[tr_q[1:0]][7:0]) ^ (pd == PD_ODD);
          ts_d = txf_q[tr_q[1:0]][9] ? TX_BRK : TX_START;
        end
      TX_BRK:
      begin
        line = bc_q == BRK_BITS;
        if (bit_tick)
        begin
          bc_d = bc_q + 4'h1;
          if (bc_q == BRK_BITS)
            ts_d = TX_IDLE;
        end
      end
      TX_START:
      begin
        line = 1'b0;
        if (bit_tick)
          ts_d = TX_DATA;
      end
      TX_DATA:
      begin
        line = sh_q[0];
        if (bit_tick)
        begin
          sh_d = {1'b0, sh_q[8:1]};
          bc_d = bc_q + 4'h1;
          if (bc_q == (nine ? 4'h8 : 4'h7))
          begin
            bc_d = 4'h0;
            ts_d = (pd == PD_EVEN || pd == PD_ODD) ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR:
      begin
        line = par_q;
        if (bit_tick)
          ts_d = TX_STOP;
      end
      TX_STOP:
        if (bit_tick)
        begin
          bc_d = bc_q + 4'h1;
          if (bc_q == {3'h0, mode_q[MODE_STSEL]})
            ts_d = TX_IDLE;
        end
      default:
        ts_d = TX_IDLE;
    endcase
    if (!on)
      ts_d = TX_IDLE;
    // Encoder sends a short high pulse for each space bit
    txd_d = ir_act ? (!line && phase < IR_PULSE) : line;
    irc_d = serial_receive_pin ? OS_LAST_STD : ((os_tick && irc_q != 4'h0) ? irc_q - 4'h1 : irc_q);
    case (mode_q[MODE_PE_LO +: 2])
      PE_NONE: rts_d = 1'b1;
      PE_BCLK: rts_d = on ? clk16 : 1'b1;
      default: rts_d = rx_full;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode_q <= MODE_RST;
      brg_q <= BRG_RST;
      {txen_q, brk_q, brk_tag_q, overrun_flag_q, txen_p_q, ev1_q, txc_q, rxc_q} <= 8'h00;
      {txis_q, rxis_q} <= 4'h0;
      {ists_q, imask_q} <= 6'h00;
      {wait_q, irq_q, txd_q, rts_q} <= 4'hB;
      rdata_q <= 32'h00000000;
      {tw_q, tr_q, rw_q, rr_q} <= 12'h000;
      ts_q <= TX_IDLE;
      sh_q <= 9'h000;
      {bc_q, irc_q} <= 8'h00;
      par_q <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
        txf_q[i] <= 10'h000;
        rxf_q[i] <= 11'h000;
      end
    end
    else
    begin
      mode_q <= mode_d;
      brg_q <= brg_d;
      {txen_q, brk_q, brk_tag_q, overrun_flag_q} <= {txen_d, brk_d, brk_tag_d, overrun_flag_d};
      {txen_p_q, ev1_q, txc_q, rxc_q} <= {txen_q, ev1_d, txc_d, rxc_d};
      {txis_q, rxis_q} <= {txis_d, rxis_d};
      {ists_q, imask_q} <= {ists_d, imask_d};
      {wait_q, irq_q, txd_q, rts_q} <= {wait_d, irq_d, txd_d, rts_d};
      rdata_q <= rdata_d;
      {tw_q, tr_q, rw_q, rr_q} <= {tw_d, tr_d, rw_d, rr_d};
      ts_q <= ts_d;
      sh_q <= sh_d;
      {bc_q, irc_q} <= {bc_d, irc_d};
      par_q <= par_d;
      txf_q <= txf_d;
      rxf_q <= rxf_d;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign irq = irq_q;
  assign serial_transmit_pin = txd_q;
  assign request_to_send_pin_n = rts_q;
endmodule : uart_tx_rx_break_infrared

// file: dv/uart_tx_rx_break_infrared_asserts.sv
// Checker of bus handshake, reset levels, interrupt hold and pin use.
// Assumes it is bound to the transceiver top and sees only its ports.
`timescale 1ns/1ps
module uart_tx_rx_break_infrared_asserts
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Interrupt and line pins
  input wire logic irq,
  input wire logic serial_receive_pin,
  input wire logic serial_transmit_pin,
  input wire logic clear_to_send_pin_n,
  input wire logic request_to_send_pin_n
);
  // ==========================================
  // Shadow of the pin enable field
  logic [1:0] pe_q;
  logic [1:0] pe_d;
  always_comb
  begin
    pe_d = pe_q;
    if (write && !waitrequest && address == REG_MODE && byteenable[1])
      pe_d = writedata[MODE_PE_LO +: 2];
  end
  always_ff @(posedge mclk)
    pe_q <= rst ? 2'h0 : pe_d;
  // ==========================================
  // Properties
  default clocking ck @(posedge mclk); endclocking
  default disable iff (rst);
  // Three cycles without a write, so no clear can land
  sequence quiet_s;
    !write ##1 irq && !write ##1 !write;
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> waitrequest && !irq &&
    serial_transmit_pin && request_to_send_pin_n) else $error("outputs not idle after reset");
  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  wait_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  wait_idle_a: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  read_hold_a: assert property (!read |=> $stable(readdata))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (read && !waitrequest && address == 5'h1C |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  txdata_zero_a: assert property (read && !waitrequest && address == REG_TXDATA |->
    readdata == 32'h0) else $error("transmit data read not zero");
  irq_hold_a: assert property (quiet_s |=> irq)
    else $error("interrupt dropped without a clear");
  rts_off_a: assert property (pe_q == PE_NONE && $past(pe_q) == PE_NONE |->
    request_to_send_pin_n) else $error("request to send active with pins unused");
endmodule : uart_tx_rx_break_infrared_asserts

// file: dv/serial_terminal.sv
// Remote terminal model: captures frames on the line, sends frames back.
// Assumes a fixed bit period in mclk cycles; its line idles high.
`timescale 1ns/1ps
module serial_terminal
#(
  parameter int BIT = 32
)
(
  // Clock
  input wire logic mclk,
  // Line
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  // ==========================================
  // Line tasks
  initial rxd = 1'b1;
  initial cts_n = 1'b0;
  // Samples mid bit, so a start found late by a few cycles is harmless
  task automatic get_frame(input int n, output logic [8:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 9'h000;
    for (i = 0; i < 20000 && txd !== 1'b0; i++)
      @(negedge mclk);
    repeat (BIT / 2) @(negedge mclk);
    for (i = 0; i < n; i++)
    begin
      repeat (BIT) @(negedge mclk);
      d[i] = txd;
    end
    repeat (BIT) @(negedge mclk);
    ok = (txd === 1'b1);
  endtask : get_frame
  task automatic put_frame(input logic [7:0] d, input logic stop);
    int i;
    for (i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? stop : d[i - 1];
      repeat (BIT - 1) @(posedge mclk);
    end
    @(posedge mclk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge mclk);
  endtask : put_frame
endmodule : serial_terminal

// file: dv/uart_tx_rx_break_infrared_bench.sv
// Self-checking bench: registers, frames, break, receive and pin modes.
// Assumes the terminal model on the line side and the bound checker.
`timescale 1ns/1ps
module uart_tx_rx_break_infrared_bench;
  import uart_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest, irq, rxd, txd, cts_n, rts_n, ok;
  logic [31:0] q;
  logic [8:0] d;
  logic [7:0] tab [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  int mismatches = 0;
  int checks_done = 0;
  int n;
  int i;
  always #12.5 mclk = ~mclk;
  uart_tx_rx_break_infrared uut (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .serial_receive_pin(rxd),
    .serial_transmit_pin(txd), .clear_to_send_pin_n(cts_n), .request_to_send_pin_n(rts_n));
  serial_terminal #(.BIT(32)) term (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  // ==========================================
  // Tasks
  task automatic close_out();
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] v,
    input logic [3:0] be, output logic [31:0] r);
    int k;
    @(posedge mclk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {16'h0000, v};
    byteenable <= be;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 100);
    if (k >= 100)
    begin
      mismatches++;
      close_out();
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wait_tx(input logic lv, input int lim, output int c);
    c = 0;
    while (txd !== lv && c < lim)
    begin
      @(negedge mclk);
      c++;
    end
  endtask : wait_tx
  task automatic count_rise(input logic pick, input int cyc, output int c);
    logic lv;
    logic now;
    c = 0;
    lv = pick ? rts_n : txd;
    repeat (cyc)
    begin
      @(negedge mclk);
      now = pick ? rts_n : txd;
      if (lv === 1'b0 && now === 1'b1)
        c++;
      lv = now;
    end
  endtask : count_rise
  // ==========================================
  // Main sequence; bit period is 32 mclk with divisor 2
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    bus(0, REG_MODE, 16'h0000, 4'hF, q);
    check("mode reset", q, 32'h0);
    bus(0, 5'h1C, 16'h0000, 4'hF, q);
    check("unmapped", q, 32'h0);
    bus(1, REG_BRG, 16'h0001, 4'hF, q);
    bus(1, REG_IMASK, 16'h0007, 4'hF, q);
    bus(1, REG_MODE, 16'h8200, 4'hF, q);
    bus(1, REG_TXDATA, 16'h003C, 4'h1, q);
    bus(1, REG_STA, 16'h0400, 4'hF, q);
    wait_tx(0, 8, n);
    check("prompt start", n < 8, 1);
    term.get_frame(8, d, ok);
    check("frame 3C", {ok, d}, {1'b1, 9'h03C});
    bus(0, REG_ISTS, 16'h0000, 4'hF, q);
    check("tx event", q, 32'h1);
    bus(1, REG_ISTS, 16'h0007, 4'hF, q);
    bus(0, REG_ISTS, 16'h0000, 4'hF, q);
    check("irq clear", irq, 1'b0);
    term.cts_n <= 1'b1;
    bus(1, REG_TXDATA, 16'h00A5, 4'h1, q);
    wait_tx(0, 200, n);
    check("cts hold", n, 200);
    @(posedge mclk);
    term.cts_n <= 1'b0;
    term.get_frame(8, d, ok);
    check("frame A5", {ok, d}, {1'b1, 9'h0A5});
    bus(1, REG_MODE, 16'h8006, 4'hF, q);
    bus(1, REG_TXDATA, 16'h01A5, 4'h1, q);
    bus(1, REG_TXDATA, 16'h01A5, 4'h3, q);
    term.get_frame(9, d, ok);
    check("frame 1A5", {ok, d}, {1'b1, 9'h1A5});
    wait_tx(0, 400, n);
    check("byte write refused", n, 400);
    bus(1, REG_MODE, 16'h8000, 4'hF, q);
    bus(1, REG_STA, 16'h0C00, 4'hF, q);
    bus(1, REG_TXDATA, 16'h00FF, 4'h1, q);
    bus(1, REG_TXDATA, 16'h0055, 4'h1, q);
    wait_tx(0, 100, n);
    wait_tx(1, 1000, n);
    check("break length", n >= 416 && n < 448, 1);
    term.get_frame(8, d, ok);
    check("sync", {ok, d}, {1'b1, 9'h055});
    bus(0, REG_STA, 16'h0000, 4'hF, q);
    check("break bit", q[STA_BRK], 1'b0);
    bus(1, REG_MODE, 16'h8002, 4'hF, q);
    bus(1, REG_TXDATA, 16'h0007, 4'h1, q);
    term.get_frame(9, d, ok);
    check("even parity", {ok, d}, {1'b1, 9'h107});
    bus(1, REG_MODE, 16'h8200, 4'hF, q);
    bus(1, REG_ISTS, 16'h0007, 4'hF, q);
    for (i = 0; i < 5; i++)
      term.put_frame(tab[i], i != 1);
    check("rts full", rts_n, 1'b1);
    bus(0, REG_ISTS, 16'h0000, 4'hF, q);
    check("rx event", q[IRQ_RX], 1'b1);
    bus(0, REG_STA, 16'h0000, 4'hF, q);
    check("status head", q[3:0], 4'h3);
    for (i = 0; i < 4; i++)
    begin
      bus(0, REG_RXDATA, 16'h0000, 4'hF, q);
      check("rx data", q[7:0], tab[i]);
      bus(0, REG_STA, 16'h0000, 4'hF, q);
      check("framing_error_flag head", q[STA_FRAMING_ERROR_FLAG], i == 0);
    end
    check("overrun kept", q[1:0], 2'h2);
    check("rts drained", rts_n, 1'b0);
    bus(1, REG_STA, 16'h0400, 4'hF, q);
    bus(0, REG_STA, 16'h0000, 4'hF, q);
    check("overrun clear", q[STA_OVERRUN_FLAG], 1'b0);
    bus(1, REG_MODE, 16'h8300, 4'hF, q);
    count_rise(1, 64, n);
    check("baud clock out", n >= 31 && n <= 32, 1);
    bus(1, REG_MODE, 16'h9000, 4'hF, q);
    count_rise(0, 8, n);
    check("ir idle", txd, 1'b0);
    bus(1, REG_TXDATA, 16'h000F, 4'h1, q);
    count_rise(0, 384, n);
    check("ir pulses", n, 5);
    close_out();
  end
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    close_out();
  end
endmodule : uart_tx_rx_break_infrared_bench
bind uart_tx_rx_break_infrared uart_tx_rx_break_infrared_asserts chk (.mclk(mclk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
  .serial_receive_pin(serial_receive_pin), .serial_transmit_pin(serial_transmit_pin),
  .clear_to_send_pin_n(clear_to_send_pin_n), .request_to_send_pin_n(request_to_send_pin_n));
